// file: nfcomc_chk.sv
/* Checker for the control register bank; watches only the top ports.
   Assumes one clock, host strobes of one cycle that never overlap. */
`timescale 1ns/1ns
module nfcomc_chk
   import nfcomc_pkg::*;
(
   // Clock, reset and host port.
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [7:0] read_data,
   // Device events.
   input wire logic crystal_stable,
   input wire logic field_on_command,
   input wire logic transmission_done,
   input wire logic reception_end,
   input wire logic peer_field_off,
   // Controls.
   input wire logic ready_state,
   input wire logic low_power_initial,
   input wire nfcomc_det_e field_detector_control,
   input wire logic receiver_enable,
   input wire logic transmitter_enable,
   input wire logic target_role,
   input wire nfcomc_proto_e operating_protocol_code,
   input wire logic modulation_kind,
   input wire logic [1:0] auto_response_field,
   input wire logic start_response_collision_avoidance
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   wire wr_oc = write_strobe && address == NFCOMC_ADDR_OPERATION_CONTROL;
   wire wr_md = write_strobe && address == NFCOMC_ADDR_MODE_DEFINITION;
   wire no_proto = operating_protocol_code == NFCOMC_PROTO_NONE;
   wire start_ca = start_response_collision_avoidance;

   property p_ready; wr_oc && write_data[7] |=> ready_state; endproperty
   a_ready: assert property (p_ready) else $error("ready state not entered");
   property p_lowpow;
      wr_oc && write_data == 8'h03 |=> low_power_initial && field_detector_control == NFCOMC_DET_AUTO;
   endproperty
   a_lowpow: assert property (p_lowpow) else $error("low power state missing");
   property p_txon; field_on_command && !no_proto |=> transmitter_enable; endproperty
   a_txon: assert property (p_txon) else $error("field on left transmitter off");
   property p_txoff;
      transmission_done && !field_on_command && !wr_oc
         && operating_protocol_code == NFCOMC_PROTO_ACTIVE_P2P |=> !transmitter_enable;
   endproperty
   a_txoff: assert property (p_txoff) else $error("transmitter not cleared");
   property p_unsup; no_proto |-> !transmitter_enable && !receiver_enable; endproperty
   a_unsup: assert property (p_unsup) else $error("reserved code left tx or rx on");
   property p_rd;
      read_strobe && address == NFCOMC_ADDR_OPERATION_CONTROL |=> read_data[7] == ready_state;
   endproperty
   a_rd: assert property (p_rd) else $error("read data disagrees with ready");
   property p_cryst;
      wr_md && !crystal_stable |=> $stable(target_role) && $stable(modulation_kind)
         && $stable(auto_response_field);
   endproperty
   a_cryst: assert property (p_cryst) else $error("mode written without crystal");
   property p_arrx; reception_end && auto_response_field == NFCOMC_AR_ANY_RX |=> start_ca; endproperty
   a_arrx: assert property (p_arrx) else $error("no response after reception");
   property p_arpeer; peer_field_off && auto_response_field == NFCOMC_AR_PEER_OFF |=> start_ca;
   endproperty
   a_arpeer: assert property (p_arpeer) else $error("no response after peer off");
   c_tx: cover property (field_on_command ##1 transmitter_enable);
   c_ca: cover property (start_ca);
   c_lp: cover property (wr_oc ##1 low_power_initial);
endmodule : nfcomc_chk

bind nfcomc_regs nfcomc_chk chk_u (.clock, .reset, .address, .write_data, .write_strobe,
   .read_strobe, .read_data, .crystal_stable, .field_on_command, .transmission_done,
   .reception_end, .peer_field_off, .ready_state, .low_power_initial, .field_detector_control,
   .receiver_enable, .transmitter_enable, .target_role, .operating_protocol_code,
   .modulation_kind, .auto_response_field, .start_response_collision_avoidance);

// file: nfcomc_host.sv
/* Host model: drives the register port with one-cycle strobes.
   Assumes the device answers reads in the cycle after the strobe. */
`timescale 1ns/1ns
module nfcomc_host (
   // Clock and device status.
   input wire logic clock,
   input wire logic crystal_stable,
   // Register port.
   output logic [7:0] address,
   output logic [7:0] write_data,
   output logic write_strobe,
   output logic read_strobe,
   input wire logic [7:0] read_data
);
   // Idle port; data is inverted after a write so stale values never pass.
   initial begin
      address = 8'h00;
      write_data = 8'h00;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
   end

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
      write_data <= ~d;
      #1;
   endtask : wr

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 d = read_data;
   endtask : rd

   // Mode writes wait up to 100 cycles for the crystal, since they are lost without it.
   task md(input logic [7:0] d);
      for (int n = 0; n < 100 && crystal_stable !== 1'b1; n++) @(posedge clock);
      wr(8'h03, d);
   endtask : md
endmodule : nfcomc_host

// file: nfcomc_pkg.sv
/*
 * Package for the operation and mode control register bank: register
 * offsets, field positions, reset values and decoded enumerations.
 * Assumes nothing of its surroundings; imported by nfcomc_regs.
 */
package nfcomc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] NFCOMC_ADDR_OPERATION_CONTROL = 8'h02;
   localparam logic [7:0] NFCOMC_ADDR_MODE_DEFINITION = 8'h03;

   // Power-up values.
   localparam logic [7:0] NFCOMC_OPERATION_CONTROL_RESET = 8'h00;
   localparam logic [7:0] NFCOMC_MODE_DEFINITION_RESET = 8'h08;

   // ----------------------------------------------------------------
   // Operation control fields
   // ----------------------------------------------------------------
   localparam int NFCOMC_OC_READY_BIT = 7;
   localparam int NFCOMC_OC_RX_EN_BIT = 6;
   localparam int NFCOMC_OC_ONE_CHANNEL_BIT = 5;
   localparam int NFCOMC_OC_MANUAL_SEL_BIT = 4;
   localparam int NFCOMC_OC_TX_EN_BIT = 3;
   localparam int NFCOMC_OC_WAKEUP_BIT = 2;
   localparam int NFCOMC_OC_FD_HI = 1;
   localparam int NFCOMC_OC_FD_LO = 0;

   localparam logic [1:0] NFCOMC_FD_OFF = 2'h0;
   localparam logic [1:0] NFCOMC_FD_MANUAL_CA = 2'h1;
   localparam logic [1:0] NFCOMC_FD_MANUAL_PEER = 2'h2;
   localparam logic [1:0] NFCOMC_FD_AUTO = 2'h3;

   // ----------------------------------------------------------------
   // Mode definition fields
   // ----------------------------------------------------------------
   localparam int NFCOMC_MD_TARGET_BIT = 7;
   localparam int NFCOMC_MD_OM_HI = 6;
   localparam int NFCOMC_MD_OM_LO = 3;
   localparam int NFCOMC_MD_MOD_BIT = 2;
   localparam int NFCOMC_MD_AR_HI = 1;
   localparam int NFCOMC_MD_AR_LO = 0;

   // Initiator operating protocol codes.
   localparam logic [3:0] NFCOMC_OM_I_ACTIVE_P2P = 4'h0;
   localparam logic [3:0] NFCOMC_OM_I_TYPE_A = 4'h1;
   localparam logic [3:0] NFCOMC_OM_I_TYPE_B = 4'h2;
   localparam logic [3:0] NFCOMC_OM_I_TYPE_F = 4'h3;
   localparam logic [3:0] NFCOMC_OM_I_TYPE_1 = 4'h4;
   localparam logic [3:0] NFCOMC_OM_I_SUBCARRIER = 4'hE;
   localparam logic [3:0] NFCOMC_OM_I_BPSK = 4'hF;
   // Target operating protocol codes.
   localparam logic [3:0] NFCOMC_OM_T_TYPE_A = 4'h1;
   localparam logic [3:0] NFCOMC_OM_T_TYPE_F = 4'h4;

   localparam logic [1:0] NFCOMC_AR_OFF = 2'h0;
   localparam logic [1:0] NFCOMC_AR_ANY_RX = 2'h1;
   localparam logic [1:0] NFCOMC_AR_PEER_OFF = 2'h2;

   // Decoded protocol selection driven to the coder and receiver.
   typedef enum logic [3:0] {
      NFCOMC_PROTO_NONE,
      NFCOMC_PROTO_ACTIVE_P2P,
      NFCOMC_PROTO_TYPE_A,
      NFCOMC_PROTO_TYPE_B,
      NFCOMC_PROTO_TYPE_F,
      NFCOMC_PROTO_TYPE_1,
      NFCOMC_PROTO_SUBCARRIER,
      NFCOMC_PROTO_BPSK,
      NFCOMC_PROTO_TARGET_A,
      NFCOMC_PROTO_TARGET_F
   } nfcomc_proto_e;

   // Receive channel usage.
   typedef enum logic [1:0] {
      NFCOMC_CH_BOTH_AUTO,
      NFCOMC_CH_BOTH_MANUAL,
      NFCOMC_CH_SINGLE
   } nfcomc_chan_e;

   // Field detector state.
   typedef enum logic [1:0] {
      NFCOMC_DET_OFF,
      NFCOMC_DET_CA,
      NFCOMC_DET_PEER,
      NFCOMC_DET_AUTO
   } nfcomc_det_e;

endpackage : nfcomc_pkg

// file: nfcomc_regs.sv
/*
 * Operation control and mode definition registers of the reader front
 * end, with the decode that steers oscillator, receiver, transmitter,
 * wake-up, field detector, protocol and automatic response logic.
 * Assumes a host on a plain strobe port synchronous to clock, and a
 * reset that is only asserted at power-up.
 */
// Added by the designer: strobed register access.
// Summary of operation
// - Ready bit enables oscillator and ready state.
// - Receive enable bit gates receiver operation.
// - Channel bit picks both or one channel.
// - Manual bit picks automatic or manual channel.
// - Transmit enable bit; field-on commands set it.
// - Active peer mode clears transmit after transmission.
// - Wake-up bit enters timer driven wake-up mode.
// - Field detector control selects off, CA, peer, auto.
// - Detector only set means low power state.
// - Operation control zeroes at power-up only.
// - Mode bit seven picks initiator or target.
// - Initiator codes decode to seven protocols.
// - Unsupported code disables transmit and receive.
// - Target codes select type A or F.
// - Modulation bit picks on-off keying or AM.
// - Auto response field control encodes two triggers.
// - Triggered auto response starts collision avoidance.
// - Mode writes accepted only with stable crystal.
`timescale 1ns/1ns

module nfcomc_regs
   import nfcomc_pkg::*;
(
   // Clock and power-up reset.
   input wire logic clock,
   input wire logic reset,
   // Host register port.
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   // Events from the rest of the device.
   input wire logic crystal_stable,
   input wire logic field_on_command,
   input wire logic transmission_done,
   input wire logic reception_end,
   input wire logic peer_field_off,
   input wire logic manual_channel_pick,
   // Analog and timer controls.
   output logic oscillator_enable,
   output logic ready_state,
   output logic wakeup_enable,
   output logic low_power_initial,
   output nfcomc_det_e field_detector_control,
   // Receiver and transmitter controls.
   output logic receiver_enable,
   output logic channel_am_enable,
   output logic channel_pm_enable,
   output logic channel_auto_select,
   output logic transmitter_enable,
   // Mode controls.
   output logic target_role,
   output nfcomc_proto_e operating_protocol_code,
   output logic modulation_kind,
   output logic [1:0] auto_response_field,
   output logic start_response_collision_avoidance
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] operation_control;
      logic [7:0] mode_definition;
      logic [7:0] read_data;
      logic start_rca;
   } nfcomc_state_s;

   nfcomc_state_s state;
   nfcomc_state_s next_state;

   // Decoded views of the stored bits and of the address.
   logic [3:0] om_code;
   logic [1:0] ar_code;
   logic proto_supported;
   nfcomc_proto_e proto;
   logic active_p2p;
   logic oc_hit;
   logic md_hit;

   // ----------------------------------------------------------------
   // Protocol decode
   // ----------------------------------------------------------------
   assign om_code = state.mode_definition[NFCOMC_MD_OM_HI:NFCOMC_MD_OM_LO];
   assign ar_code = state.mode_definition[NFCOMC_MD_AR_HI:NFCOMC_MD_AR_LO];

   // Role decides how the four bit code reads; reserved codes give NONE.
   always_comb begin
      proto = NFCOMC_PROTO_NONE;
      if (state.mode_definition[NFCOMC_MD_TARGET_BIT]) begin
         case (om_code)
            NFCOMC_OM_T_TYPE_A: proto = NFCOMC_PROTO_TARGET_A;
            NFCOMC_OM_T_TYPE_F: proto = NFCOMC_PROTO_TARGET_F;
            default: proto = NFCOMC_PROTO_NONE;
         endcase
      end else begin
         case (om_code)
            NFCOMC_OM_I_ACTIVE_P2P: proto = NFCOMC_PROTO_ACTIVE_P2P;
            NFCOMC_OM_I_TYPE_A: proto = NFCOMC_PROTO_TYPE_A;
            NFCOMC_OM_I_TYPE_B: proto = NFCOMC_PROTO_TYPE_B;
            NFCOMC_OM_I_TYPE_F: proto = NFCOMC_PROTO_TYPE_F;
            NFCOMC_OM_I_TYPE_1: proto = NFCOMC_PROTO_TYPE_1;
            NFCOMC_OM_I_SUBCARRIER: proto = NFCOMC_PROTO_SUBCARRIER;
            NFCOMC_OM_I_BPSK: proto = NFCOMC_PROTO_BPSK;
            default: proto = NFCOMC_PROTO_NONE;
         endcase
      end
   end

   assign proto_supported = (proto != NFCOMC_PROTO_NONE);
   assign active_p2p = (proto == NFCOMC_PROTO_ACTIVE_P2P);
   assign oc_hit = (address == NFCOMC_ADDR_OPERATION_CONTROL);
   assign md_hit = (address == NFCOMC_ADDR_MODE_DEFINITION);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // A device update of the transmit bit in the same cycle as a host
   // write overrides the written bit, so the hardware event is not lost.
   always_comb begin
      next_state = state;
      next_state.read_data = 8'h00;
      next_state.start_rca = 1'b0;
      if (write_strobe && oc_hit) begin
         next_state.operation_control = write_data;
      end
      // Mode writes without a stable crystal are dropped silently.
      if (write_strobe && md_hit && crystal_stable) begin
         next_state.mode_definition = write_data;
      end
      if (active_p2p && transmission_done) begin
         next_state.operation_control[NFCOMC_OC_TX_EN_BIT] = 1'b0;
      end
      if (field_on_command) begin
         next_state.operation_control[NFCOMC_OC_TX_EN_BIT] = 1'b1;
      end
      // Reads see the stored values, device changes included.
      if (read_strobe) begin
         if (oc_hit) begin
            next_state.read_data = state.operation_control;
         end else if (md_hit) begin
            next_state.read_data = state.mode_definition;
         end else begin
            next_state.read_data = 8'h00;
         end
      end
      case (ar_code)
         NFCOMC_AR_ANY_RX: next_state.start_rca = reception_end;
         NFCOMC_AR_PEER_OFF: next_state.start_rca = peer_field_off;
         default: next_state.start_rca = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // The only reset is power-up, so defaults load only then.
   always_ff @(posedge clock) begin
      if (reset) begin
         state.operation_control <= NFCOMC_OPERATION_CONTROL_RESET;
         state.mode_definition <= NFCOMC_MODE_DEFINITION_RESET;
         state.read_data <= 8'h00;
         state.start_rca <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign read_data = state.read_data;
   assign oscillator_enable = state.operation_control[NFCOMC_OC_READY_BIT];
   assign ready_state = state.operation_control[NFCOMC_OC_READY_BIT];
   assign wakeup_enable = state.operation_control[NFCOMC_OC_WAKEUP_BIT];

   // Detector field maps straight onto its four states.
   always_comb begin
      case (state.operation_control[NFCOMC_OC_FD_HI:NFCOMC_OC_FD_LO])
         NFCOMC_FD_MANUAL_CA: field_detector_control = NFCOMC_DET_CA;
         NFCOMC_FD_MANUAL_PEER: field_detector_control = NFCOMC_DET_PEER;
         NFCOMC_FD_AUTO: field_detector_control = NFCOMC_DET_AUTO;
         default: field_detector_control = NFCOMC_DET_OFF;
      endcase
   end

   // Detector alone, every other control bit clear.
   assign low_power_initial =
      (state.operation_control[NFCOMC_OC_FD_HI:NFCOMC_OC_FD_LO] != NFCOMC_FD_OFF) &&
      (state.operation_control[7:2] == 6'h00);

   // Unsupported protocol codes hold both directions off.
   assign receiver_enable = state.operation_control[NFCOMC_OC_RX_EN_BIT]
                            && proto_supported;
   assign transmitter_enable = state.operation_control[NFCOMC_OC_TX_EN_BIT]
                               && proto_supported;

   // Single channel follows the manual pick: 0 selects AM, 1 PM.
   always_comb begin
      if (state.operation_control[NFCOMC_OC_ONE_CHANNEL_BIT]) begin
         channel_am_enable = receiver_enable && !manual_channel_pick;
         channel_pm_enable = receiver_enable && manual_channel_pick;
         channel_auto_select = 1'b0;
      end else begin
         channel_am_enable = receiver_enable;
         channel_pm_enable = receiver_enable;
         channel_auto_select = !state.operation_control[NFCOMC_OC_MANUAL_SEL_BIT];
      end
   end

   assign target_role = state.mode_definition[NFCOMC_MD_TARGET_BIT];
   assign operating_protocol_code = proto;
   assign modulation_kind = state.mode_definition[NFCOMC_MD_MOD_BIT];
   assign auto_response_field = ar_code;
   assign start_response_collision_avoidance = state.start_rca;

endmodule : nfcomc_regs

// file: testbench.sv
/* Self-checking bench for the control register bank.
   Assumes the host model and checker files are compiled before it. */
`timescale 1ns/1ns
module testbench;
   import nfcomc_pkg::*;
   logic clock, reset, crystal_stable, manual_channel_pick, write_strobe, read_strobe;
   logic field_on_command, transmission_done, reception_end, peer_field_off;
   logic [7:0] address, write_data, read_data, got, m;
   logic oscillator_enable, ready_state, wakeup_enable, low_power_initial, receiver_enable;
   logic channel_am_enable, channel_pm_enable, channel_auto_select, transmitter_enable;
   logic target_role, modulation_kind, start_response_collision_avoidance;
   logic [1:0] auto_response_field;
   nfcomc_det_e field_detector_control;
   nfcomc_proto_e operating_protocol_code;
   int mismatches = 0, tests_run = 0;
   // Channel table: control byte and {am, pm, auto}; pick is the index's low bit.
   logic [7:0] ch_t [6] = '{8'h40, 8'h50, 8'h60, 8'h60, 8'h20, 8'h00};
   logic [7:0] cx_t [6] = '{8'h07, 8'h06, 8'h04, 8'h02, 8'h00, 8'h01};
   // Mode bytes and expected protocol, numbered in enumeration order.
   logic [7:0] md_t [11] = '{8'h00, 8'h0C, 8'h10, 8'h1C, 8'h20, 8'h74, 8'h78, 8'h28,
      8'h88, 8'hA4, 8'h80};
   logic [3:0] ep_t [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h8, 4'h9, 4'h0};

   nfcomc_regs dut_u (.*);
   nfcomc_host host_u (.clock, .crystal_stable, .address, .write_data, .write_strobe,
      .read_strobe, .read_data);

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task chk_rd(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, got);
      chk(got, e);
   endtask : chk_rd

   // Event pulses in order field on, done, reception end, peer off.
   task evt(input logic [3:0] v);
      @(posedge clock);
      {field_on_command, transmission_done, reception_end, peer_field_off} <= v;
      @(posedge clock);
      {field_on_command, transmission_done, reception_end, peer_field_off} <= 4'h0;
      #1;
   endtask : evt

   task final_report;
      $display("tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   // A hang ends the run as a failure well beyond the expected length.
   initial begin
      #100000;
      mismatches++;
      final_report;
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      crystal_stable = 1'b1;
      manual_channel_pick = 1'b0;
      {field_on_command, transmission_done, reception_end, peer_field_off} = 4'h0;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      chk_rd(8'h02, 8'h00);
      chk_rd(8'h03, 8'h08);
      chk_rd(8'h05, 8'h00);
      host_u.wr(8'h02, 8'hC8);
      chk({ready_state, oscillator_enable, receiver_enable, transmitter_enable, 4'h0}, 8'hF0);
      chk_rd(8'h02, 8'hC8);
      for (int i = 0; i < 6; i++) begin
         manual_channel_pick <= i[0];
         host_u.wr(8'h02, ch_t[i]);
         chk({5'h00, channel_am_enable, channel_pm_enable, channel_auto_select}, cx_t[i]);
      end
      for (int i = 0; i < 4; i++) begin
         host_u.wr(8'h02, i[7:0]);
         chk({field_detector_control, 5'h00, low_power_initial}, {i[1:0], 5'h00, i != 0});
      end
      host_u.wr(8'h02, 8'h05);
      chk({6'h00, wakeup_enable, low_power_initial}, 8'h02);
      host_u.wr(8'h02, 8'hC8);
      for (int i = 0; i < 11; i++) begin
         host_u.md(md_t[i]);
         m = md_t[i];
         chk({operating_protocol_code, transmitter_enable, receiver_enable, target_role, modulation_kind},
            {ep_t[i], {2{ep_t[i] != 4'h0}}, m[7], m[2]});
      end
      crystal_stable <= 1'b0;
      host_u.wr(8'h03, 8'h7F);
      chk_rd(8'h03, 8'h80);
      crystal_stable <= 1'b1;
      host_u.md(8'h00);
      host_u.wr(8'h02, 8'h8B);
      evt(4'h4);
      chk_rd(8'h02, 8'h83);
      evt(4'hC);
      chk_rd(8'h02, 8'h8B);
      host_u.md(8'h08);
      host_u.wr(8'h02, 8'h81);
      evt(4'h8);
      evt(4'h4);
      chk_rd(8'h02, 8'h89);
      for (int i = 0; i < 4; i++) begin
         host_u.md(8'h08 | i[7:0]);
         chk({6'h00, auto_response_field}, i[7:0]);
         evt(4'h2);
         chk({7'h00, start_response_collision_avoidance}, {7'h00, i == 1});
         evt(4'h1);
         chk({7'h00, start_response_collision_avoidance}, {7'h00, i == 2});
      end
      final_report;
   end
endmodule : testbench
